/* mcep_consts.svh */
// register offsets, field positions and address map of the memory controller
`ifndef MCEP_CONSTS_SVH
`define MCEP_CONSTS_SVH
// register byte offsets on the control bus
`define MCEP_IRQ_STAT 8'h00
`define MCEP_IRQ_MASK 8'h04
`define MCEP_ECC_ADDR 8'h08
`define MCEP_FL_ADDR 8'h0C
`define MCEP_FL_DATA 8'h10
`define MCEP_FL_CMD 8'h14
`define MCEP_PROT_LVL 8'h18
`define MCEP_RD_BLK_LO 8'h1C
`define MCEP_RD_BLK_HI 8'h20
`define MCEP_WR_BLK_LO 8'h24
`define MCEP_WR_BLK_HI 8'h28
// status and mask bit positions
`define MCEP_IRQ_SBE 0
`define MCEP_IRQ_DBE 1
`define MCEP_IRQ_FDONE 2
`define MCEP_IRQ_FREF 3
`define MCEP_IRQ_W 4
// flash command codes
`define MCEP_CMD_PROG 2'h1
`define MCEP_CMD_ERASE 2'h2
// address map: flash space page numbers, sram nibble
`define MCEP_SRAM_NIB 4'h2
`define MCEP_MAIN_PAGES 8'h80
`define MCEP_INFO_PAGE_A 8'h80
`define MCEP_INFO_PAGE_B 8'h81
`define MCEP_INFO_PAGE_U 8'h82
`define MCEP_SRAM_WORDS 8192
`define MCEP_REGIONS 64
// protection levels
`define MCEP_LVL_OPEN 2'h0
`define MCEP_LVL_DBGOFF 2'h2
`define MCEP_LVL_FINAL 2'h3
`endif

/* mcep_ctrl.sv */
// memory controller: flash reader, ecc sram, code protection, control regs
// Overview of operation
// - main flash seen on the bus as 128 pages of one kilobyte each
// - one flash page erased or programmed while sram keeps serving
// - read buffer fetches the next flash word ahead of demand
// - three information pages of one kilobyte each, three kilobytes total
// - first two information pages are read only and hold factory data
// - third information page is readable and writable by user software
// - 32 kilobyte sram taking word, half-word and byte accesses
// - sram access runs at full bus clock, also for instruction fetch
// - sram words carry code correcting one bit and detecting two
// - corrected single-bit error is flagged in a readable status bit
// - single-bit error raises interrupt when its enable is set
// - double-bit error raises interrupt when its enable is set
// - partial sram write is read, merge, write and takes several cycles
// - four protection levels zero to three, zero has no restriction
// - levels one to three protect up to 64 flash regions
// - each region can block reads or writes separately
// - flash, info pages and sram share one flat map, registers sit on the control bus
//
// Design decisions made here: the address map and the Wishbone slave port.
`include "mcep_consts.svh"
module mcep_ctrl #(
	parameter int SRAM_WORDS = `MCEP_SRAM_WORDS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// processor memory bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hready_o,
	output logic hresp_o,
	// control register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// flash array port
	output logic fl_rd_o,
	output logic [15:0] fl_raddr_o,
	input wire logic [31:0] fl_rdata_i,
	input wire logic fl_rvalid_i,
	output logic fl_prog_o,
	output logic fl_erase_o,
	output logic [15:0] fl_paddr_o,
	output logic [31:0] fl_pdata_o,
	input wire logic fl_done_i,
	// stored protection level and system outputs
	input wire logic [1:0] prot_boot_i,
	output logic irq_o,
	output logic debug_en_o
);
	localparam int AW = $clog2(SRAM_WORDS);

	// elaboration check: the index logic needs a power of two
	if (SRAM_WORDS < 2 || SRAM_WORDS > `MCEP_SRAM_WORDS ||
		(SRAM_WORDS & (SRAM_WORDS - 1)) != 0) begin : g_size_chk
		$error("SRAM_WORDS must be a power of two up to 8192");
	end

	// encode: data bits in non-power-of-two slots, hamming parity, overall
	function automatic logic [38:0] ecc_enc(input logic [31:0] d);
		logic [38:0] c;
		logic [5:0] s;
		int k;
		c = '0;
		s = '0;
		k = 0;
		for (int i = 1; i < 39; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = d[k];
				if (d[k])
					s = s ^ i[5:0];
				k++;
			end
		end
		for (int p = 0; p < 6; p++)
			c[1 << p] = s[p];
		c[0] = ^c[38:1];
		return c;
	endfunction

	// decode: returns {double, single, corrected data}
	function automatic logic [33:0] ecc_dec(input logic [38:0] code);
		logic [38:0] c;
		logic [5:0] s;
		logic [31:0] d;
		logic par;
		int k;
		c = code;
		s = '0;
		d = '0;
		k = 0;
		for (int i = 1; i < 39; i++)
			if (c[i])
				s = s ^ i[5:0];
		par = ^c;
		if (par && s != 6'h00 && s < 6'd39)
			c[s] = ~c[s];
		for (int i = 1; i < 39; i++) begin
			if ((i & (i - 1)) != 0) begin
				d[k] = c[i];
				k++;
			end
		end
		return {(!par && s != 6'h00), par, d};
	endfunction

	// byte lanes touched by an aligned transfer
	function automatic logic [3:0] lanes(input logic [2:0] sz,
		input logic [1:0] a);
		case (sz)
			3'h0: lanes = 4'h1 << a;
			3'h1: lanes = a[1] ? 4'hC : 4'h3;
			default: lanes = 4'hF;
		endcase
	endfunction

	// replace the selected byte lanes of a word
	function automatic logic [31:0] bmerge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			if (be[b])
				o[b*8 +: 8] = n[b*8 +: 8];
		return o;
	endfunction

	mcep_pkg::mcep_state_t state;
	logic [38:0] sram [SRAM_WORDS];
	logic [38:0] mem_q;
	logic [33:0] dec;
	logic [AW-1:0] q_idx;
	logic [15:0] q_word;
	logic [3:0] q_lanes;
	logic q_wr;
	logic [31:0] q_wdata;
	logic pf_valid;
	logic [15:0] pf_addr;
	logic [31:0] pf_data;
	logic launch;
	logic [15:0] launch_addr;
	logic [1:0] prot_level;
	logic lvl_loaded;
	logic [63:0] rd_blk;
	logic [63:0] wr_blk;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [AW-1:0] ecc_addr;
	logic [17:0] fl_addr;
	logic [31:0] fl_data;
	logic cap, a_sram, a_main, a_info, bad_req, pf_hit, prog_busy;
	logic wb_hit, wb_wr;
	logic [7:0] wb_off;
	logic [7:0] t_page;
	logic cmd_go, cmd_ok;
	logic [1:0] cmd;
	logic [3:0] ev;

	// request decode over the flat map
	always_comb begin
		cap = (state == mcep_pkg::S_IDLE) && hsel_i && htrans_i[1];
		a_sram = haddr_i[31:28] == `MCEP_SRAM_NIB &&
			haddr_i[27:2] < 26'(SRAM_WORDS);
		a_main = haddr_i[31:18] == 14'h0000 &&
			haddr_i[17:10] < `MCEP_MAIN_PAGES;
		a_info = haddr_i[31:18] == 14'h0000 &&
			haddr_i[17:10] >= `MCEP_INFO_PAGE_A &&
			haddr_i[17:10] <= `MCEP_INFO_PAGE_U;
		bad_req = !(a_sram || a_main || a_info) || hsize_i > 3'h2 ||
			(!a_sram && hwrite_i) ||
			(a_main && prot_level != `MCEP_LVL_OPEN &&
			rd_blk[haddr_i[16:11]]);
	end

	always_comb dec = ecc_dec(mem_q);
	always_comb prog_busy = fl_prog_o || fl_erase_o;
	always_comb pf_hit = pf_valid && pf_addr == q_word && !prog_busy;

	// flash reader: demand fetch on a miss, next word once a hit is served
	always_comb begin
		launch = 1'b0;
		launch_addr = q_word;
		if (state == mcep_pkg::S_FRD && !prog_busy && !fl_rd_o) begin
			launch = 1'b1;
			if (pf_hit)
				launch_addr = q_word + 16'h0001;
		end
	end

	// bus transfer sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= mcep_pkg::S_IDLE;
			hready_o <= 1'b1;
			hresp_o <= 1'b0;
			hrdata_o <= 32'h0000_0000;
			q_idx <= '0;
			q_word <= 16'h0000;
			q_lanes <= 4'h0;
			q_wr <= 1'b0;
			q_wdata <= 32'h0000_0000;
		end else begin
			case (state)
				mcep_pkg::S_IDLE: begin
					hresp_o <= 1'b0;
					if (cap) begin
						hready_o <= 1'b0;
						q_idx <= haddr_i[AW+1:2];
						q_word <= haddr_i[17:2];
						q_lanes <= lanes(hsize_i, haddr_i[1:0]);
						q_wr <= hwrite_i;
						if (bad_req) begin
							hresp_o <= 1'b1;
							state <= mcep_pkg::S_ERR;
						end else if (a_sram)
							state <= mcep_pkg::S_SACC;
						else
							state <= mcep_pkg::S_FRD;
					end
				end
				mcep_pkg::S_SACC: begin
					q_wdata <= hwdata_i;
					if (q_wr && q_lanes == 4'hF) begin
						hready_o <= 1'b1;
						state <= mcep_pkg::S_IDLE;
					end else if (q_wr)
						state <= mcep_pkg::S_SMRG;
					else
						state <= mcep_pkg::S_SRD;
				end
				mcep_pkg::S_SRD, mcep_pkg::S_SMRG: begin
					hrdata_o <= dec[31:0];
					if (dec[33]) begin
						hresp_o <= 1'b1;
						state <= mcep_pkg::S_ERR;
					end else begin
						hready_o <= 1'b1;
						state <= mcep_pkg::S_IDLE;
					end
				end
				mcep_pkg::S_FRD: begin
					if (pf_hit) begin
						hrdata_o <= pf_data;
						hready_o <= 1'b1;
						state <= mcep_pkg::S_IDLE;
					end
				end
				mcep_pkg::S_ERR: begin
					hready_o <= 1'b1;
					state <= mcep_pkg::S_IDLE;
				end
				default: begin
					hready_o <= 1'b1;
					state <= mcep_pkg::S_IDLE;
				end
			endcase
		end
	end

	// sram array with check bits; partial writes merge the corrected word
	always_ff @(posedge clk_i) begin
		if (state == mcep_pkg::S_SACC)
			mem_q <= sram[q_idx];
		if (state == mcep_pkg::S_SACC && q_wr && q_lanes == 4'hF)
			sram[q_idx] <= ecc_enc(hwdata_i);
		if (state == mcep_pkg::S_SMRG && !dec[33])
			sram[q_idx] <= ecc_enc(bmerge(dec[31:0], q_wdata, q_lanes));
	end

	// flash read engine and look-ahead buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_rd_o <= 1'b0;
			fl_raddr_o <= 16'h0000;
			pf_valid <= 1'b0;
			pf_addr <= 16'h0000;
			pf_data <= 32'h0000_0000;
		end else begin
			if (fl_rd_o && fl_rvalid_i) begin
				fl_rd_o <= 1'b0;
				pf_data <= fl_rdata_i;
				pf_addr <= fl_raddr_o;
				pf_valid <= 1'b1;
			end else if (launch) begin
				fl_rd_o <= 1'b1;
				fl_raddr_o <= launch_addr;
			end
			if (fl_done_i)
				pf_valid <= 1'b0; // stale after program or erase
		end
	end

	// control bus decode
	always_comb begin
		wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wb_wr = wb_hit && wb_we_i;
		wb_off = {wb_adr_i[7:2], 2'b00};
		cmd = wb_dat_i[1:0] & {2{wb_sel_i[0]}};
		cmd_go = wb_wr && wb_off == `MCEP_FL_CMD && cmd != 2'h0 && !prog_busy;
		t_page = fl_addr[17:10];
		cmd_ok = (t_page == `MCEP_INFO_PAGE_U) ||
			(t_page < `MCEP_MAIN_PAGES &&
			!(prot_level != `MCEP_LVL_OPEN && wr_blk[fl_addr[16:11]]));
	end

	// bus answer: ack one cycle after the strobe, read data in the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit && !wb_we_i) begin
				case (wb_off)
					`MCEP_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
					`MCEP_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
					`MCEP_ECC_ADDR: wb_dat_o <= 32'(ecc_addr);
					`MCEP_FL_ADDR: wb_dat_o <= {14'h0, fl_addr};
					`MCEP_FL_DATA: wb_dat_o <= fl_data;
					`MCEP_FL_CMD: wb_dat_o <= {30'h0, fl_erase_o, fl_prog_o};
					`MCEP_PROT_LVL: wb_dat_o <= {30'h0, prot_level};
					`MCEP_RD_BLK_LO: wb_dat_o <= rd_blk[31:0];
					`MCEP_RD_BLK_HI: wb_dat_o <= rd_blk[63:32];
					`MCEP_WR_BLK_LO: wb_dat_o <= wr_blk[31:0];
					`MCEP_WR_BLK_HI: wb_dat_o <= wr_blk[63:32];
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// flash command registers and program/erase sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_addr <= 18'h00000;
			fl_data <= 32'h0000_0000;
			fl_prog_o <= 1'b0;
			fl_erase_o <= 1'b0;
			fl_paddr_o <= 16'h0000;
			fl_pdata_o <= 32'h0000_0000;
		end else begin
			if (wb_wr && wb_off == `MCEP_FL_ADDR)
				fl_addr <= 18'(bmerge({14'h0, fl_addr}, wb_dat_i, wb_sel_i));
			if (wb_wr && wb_off == `MCEP_FL_DATA)
				fl_data <= bmerge(fl_data, wb_dat_i, wb_sel_i);
			if (prog_busy && fl_done_i) begin
				fl_prog_o <= 1'b0;
				fl_erase_o <= 1'b0;
			end else if (cmd_go && cmd_ok) begin
				fl_prog_o <= cmd == `MCEP_CMD_PROG;
				fl_erase_o <= cmd == `MCEP_CMD_ERASE;
				fl_paddr_o <= fl_addr[17:2];
				fl_pdata_o <= fl_data;
			end
		end
	end

	// protection level: loaded once after reset, level three frozen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prot_level <= `MCEP_LVL_OPEN;
			lvl_loaded <= 1'b0;
			rd_blk <= 64'h0;
			wr_blk <= 64'h0;
			debug_en_o <= 1'b1;
		end else begin
			lvl_loaded <= 1'b1;
			if (!lvl_loaded)
				prot_level <= prot_boot_i;
			else if (prot_level != `MCEP_LVL_FINAL) begin
				if (wb_wr && wb_off == `MCEP_PROT_LVL && wb_sel_i[0])
					prot_level <= wb_dat_i[1:0];
				if (wb_wr && wb_off == `MCEP_RD_BLK_LO)
					rd_blk[31:0] <= bmerge(rd_blk[31:0], wb_dat_i, wb_sel_i);
				if (wb_wr && wb_off == `MCEP_RD_BLK_HI)
					rd_blk[63:32] <= bmerge(rd_blk[63:32], wb_dat_i, wb_sel_i);
				if (wb_wr && wb_off == `MCEP_WR_BLK_LO)
					wr_blk[31:0] <= bmerge(wr_blk[31:0], wb_dat_i, wb_sel_i);
				if (wb_wr && wb_off == `MCEP_WR_BLK_HI)
					wr_blk[63:32] <= bmerge(wr_blk[63:32], wb_dat_i, wb_sel_i);
			end
			debug_en_o <= prot_level < `MCEP_LVL_DBGOFF;
		end
	end

	// event sources for the sticky status bits
	always_comb begin
		ev = 4'h0;
		if (state == mcep_pkg::S_SRD || state == mcep_pkg::S_SMRG) begin
			ev[`MCEP_IRQ_SBE] = dec[32];
			ev[`MCEP_IRQ_DBE] = dec[33];
		end
		ev[`MCEP_IRQ_FDONE] = prog_busy && fl_done_i;
		ev[`MCEP_IRQ_FREF] = cmd_go && !cmd_ok;
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			ecc_addr <= '0;
			irq_o <= 1'b0;
		end else begin
			if (wb_wr && wb_off == `MCEP_IRQ_STAT && wb_sel_i[0])
				irq_stat <= (irq_stat & ~wb_dat_i[3:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			if (wb_wr && wb_off == `MCEP_IRQ_MASK && wb_sel_i[0])
				irq_mask <= wb_dat_i[3:0];
			if (ev[`MCEP_IRQ_SBE] || ev[`MCEP_IRQ_DBE])
				ecc_addr <= q_idx;
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence sub_write_seq;
		cap && !bad_req && a_sram && hwrite_i && hsize_i != 3'h2;
	endsequence
	sequence two_wait_seq;
		!hready_o ##1 !hready_o ##1 hready_o;
	endsequence
	sequence err_resp_seq;
		hresp_o && !hready_o ##1 hresp_o && hready_o;
	endsequence

	rmw_latency_a: assert property (sub_write_seq |=> two_wait_seq)
		else $error("partial sram write did not take two wait cycles");
	word_write_a: assert property (cap && !bad_req && a_sram && hwrite_i &&
		hsize_i == 3'h2 |=> !hready_o ##1 hready_o)
		else $error("word sram write not done in one wait cycle");
	final_level_a: assert property (prot_level == `MCEP_LVL_FINAL && lvl_loaded
		|=> prot_level == `MCEP_LVL_FINAL && $stable(rd_blk))
		else $error("level three was left or regions changed");
	debug_gate_a: assert property (lvl_loaded && prot_level >= 2'h2
		|=> !debug_en_o)
		else $error("debug port open at level two or three");
	region_block_a: assert property (cap && a_main && !hwrite_i &&
		hsize_i <= 3'h2 && prot_level != 2'h0 && rd_blk[haddr_i[16:11]]
		|=> err_resp_seq)
		else $error("blocked flash region was readable");
	level_open_a: assert property (cap && a_main && !hwrite_i &&
		hsize_i <= 3'h2 && prot_level == 2'h0 |=> !hresp_o [*2])
		else $error("level zero refused a flash read");
	sbe_flag_a: assert property (state == mcep_pkg::S_SRD && dec[32]
		|=> irq_stat[`MCEP_IRQ_SBE] ##1 irq_stat[`MCEP_IRQ_SBE] || $past(wb_wr))
		else $error("corrected error not flagged");
	irq_level_a: assert property ((irq_stat & irq_mask) != 4'h0
		|=> irq_o)
		else $error("unmasked status bit gave no interrupt");
	factory_guard_a: assert property (cmd_go &&
		(t_page == `MCEP_INFO_PAGE_A || t_page == `MCEP_INFO_PAGE_B)
		|=> !fl_prog_o && !fl_erase_o && irq_stat[`MCEP_IRQ_FREF])
		else $error("factory page accepted a program or erase");
	pf_hit_a: assert property (state == mcep_pkg::S_FRD && pf_hit
		|=> hready_o && hrdata_o == $past(pf_data))
		else $error("buffered flash word not returned next cycle");
endmodule

/* mcep_flash_model.sv */
// flash array model answering read, program and erase requests
module mcep_flash_model #(
	parameter int RD_CYC = 2,
	parameter int PE_CYC = 30
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// read port
	input wire logic rd_i,
	input wire logic [15:0] raddr_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o,
	// program and erase port
	input wire logic prog_i,
	input wire logic erase_i,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int rcnt;
	int pcnt;
	// read answer after a fixed delay; data toggles outside the pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcnt <= 0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
		end else begin
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o; // no stale word between answers
			if (rvalid_o)
				rcnt <= 0;
			else if (rd_i && rcnt == RD_CYC) begin
				rvalid_o <= 1'b1;
				rdata_o <= {~raddr_i, raddr_i};
			end else if (rd_i)
				rcnt <= rcnt + 1;
		end
	end
	// program or erase ends with a one-cycle done pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pcnt <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (done_o)
				pcnt <= 0;
			else if ((prog_i || erase_i) && pcnt == PE_CYC)
				done_o <= 1'b1;
			else if (prog_i || erase_i)
				pcnt <= pcnt + 1;
		end
	end
endmodule

/* mcep_pkg.sv */
// types shared by the memory controller
package mcep_pkg;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_SACC = 6'h02,
		S_SRD = 6'h04,
		S_SMRG = 6'h08,
		S_FRD = 6'h10,
		S_ERR = 6'h20
	} mcep_state_t;
endpackage

/* memory_controller_ecc_protect_tb_top.sv */
// self-checking bench for the memory controller
`include "mcep_consts.svh"
module memory_controller_ecc_protect_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [3:0] sel_req = 4'hF;
	logic [31:0] hrdata_o, wb_dat_o, fl_rdata_i, fl_pdata_o;
	logic [15:0] fl_raddr_o, fl_paddr_o;
	logic hready_o, hresp_o, wb_ack_o, fl_rd_o, fl_rvalid_i, fl_prog_o;
	logic fl_erase_o, fl_done_i, irq_o, debug_en_o;
	int n_fail = 0;
	int checked = 0;
	int nw;
	logic [31:0] rd;
	logic er;
	// clock generation
	always #5 clk_i = ~clk_i;
	// design and flash array
	mcep_ctrl #(.SRAM_WORDS(64)) uut (.clk_i, .rst_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hrdata_o, .hready_o,
		.hresp_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fl_rd_o,
		.fl_raddr_o, .fl_rdata_i, .fl_rvalid_i, .fl_prog_o, .fl_erase_o,
		.fl_paddr_o, .fl_pdata_o, .fl_done_i, .prot_boot_i(2'h0), .irq_o,
		.debug_en_o);
	mcep_flash_model flash (.clk_i, .rst_i, .rd_i(fl_rd_o),
		.raddr_i(fl_raddr_o), .rdata_o(fl_rdata_i), .rvalid_o(fl_rvalid_i),
		.prog_i(fl_prog_o), .erase_i(fl_erase_o), .done_o(fl_done_i));
	// compare and verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// a wait that ran out counts as a mismatch
	task automatic lim(input logic hit);
		if (hit !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t handshake timeout", $time);
		end
	endtask
	task automatic summarize;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one processor bus transfer, address phase then data phase
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [2:0] sz, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		hsize_i <= sz;
		@(posedge clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		nw = 0;
		do begin
			@(posedge clk_i);
			nw++;
		end while (hready_o !== 1'b1 && nw < 200);
		lim(hready_o === 1'b1);
		rd = hrdata_o;
		er = hresp_o;
	endtask
	// one classic wishbone cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel_req;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		lim(wb_ack_o === 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// bounded wait for the interrupt line
	task automatic wirq;
		int i;
		i = 0;
		while (irq_o !== 1'b1 && i < 100) begin
			@(posedge clk_i);
			i++;
		end
		lim(irq_o === 1'b1);
	endtask
	// status read, check and clear
	task automatic stat(input logic [3:0] e);
		wb(0, `MCEP_IRQ_STAT, 32'h0);
		chk({28'h0, rd[3:0]}, {28'h0, e});
		wb(1, `MCEP_IRQ_STAT, 32'hF);
	endtask
	// reset state and register bus basics
	task automatic t_reset;
		chk(hready_o, 1'b1);
		chk(debug_en_o, 1'b1);
		chk(irq_o, 1'b0);
		wb(0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		wb(1, `MCEP_IRQ_MASK, 32'hC);
		wb(0, `MCEP_IRQ_MASK, 32'h0);
		chk(rd, 32'hC);
		sel_req = 4'h0;
		wb(1, `MCEP_IRQ_MASK, 32'h3);
		sel_req = 4'hF;
		wb(0, `MCEP_IRQ_MASK, 32'h0);
		chk(rd, 32'hC);
	endtask
	// sram word and partial writes, errors on bad size or address
	task automatic t_sram;
		int nword;
		ahb(1, 32'h2000_0010, 3'h2, 32'h1122_3344);
		nword = nw;
		ahb(0, 32'h2000_0010, 3'h2, 32'h0);
		chk(rd, 32'h1122_3344);
		ahb(1, 32'h2000_0011, 3'h0, 32'h0000_AA00);
		chk(nw > nword, 1'b1);
		ahb(1, 32'h2000_0012, 3'h1, 32'hBEEF_0000);
		ahb(0, 32'h2000_0010, 3'h2, 32'h0);
		chk(rd, 32'hBEEF_AA44);
		chk(er, 1'b0);
		ahb(0, 32'h2000_0010, 3'h3, 32'h0);
		chk(er, 1'b1);
		ahb(0, 32'h1000_0000, 3'h2, 32'h0);
		chk(er, 1'b1);
	endtask
	// flash reads, look-ahead hit and information pages
	task automatic t_flash;
		int miss;
		int i;
		ahb(0, 32'h0001_FFFC, 3'h2, 32'h0);
		chk(rd, 32'h8000_7FFF);
		ahb(0, 32'h0000_0400, 3'h2, 32'h0);
		miss = nw;
		chk(rd, 32'hFEFF_0100);
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (fl_rd_o === 1'b1 && i < 50);
		ahb(0, 32'h0000_0404, 3'h2, 32'h0);
		chk(rd, 32'hFEFE_0101);
		chk(nw < miss, 1'b1);
		ahb(0, 32'h0002_0000, 3'h2, 32'h0);
		chk(rd, 32'h7FFF_8000);
		ahb(0, 32'h0002_0400, 3'h2, 32'h0);
		chk(rd, 32'h7EFF_8100);
		ahb(0, 32'h0002_0800, 3'h2, 32'h0);
		chk(rd, 32'h7DFF_8200);
		ahb(1, 32'h0002_0000, 3'h2, 32'h0);
		chk(er, 1'b1);
		ahb(0, 32'h0002_0C00, 3'h2, 32'h0);
		chk(er, 1'b1);
	endtask
	// flash commands: refused pages, user page program, erase beside sram
	task automatic t_cmd;
		int i;
		for (i = 0; i < 2; i++) begin
			wb(1, `MCEP_FL_ADDR, 32'h0002_0000 + 32'h400 * i);
			wb(1, `MCEP_FL_CMD, {30'h0, `MCEP_CMD_PROG});
			wirq;
			chk(fl_prog_o, 1'b0);
			chk(irq_o, 1'b1);
			stat(4'h8);
		end
		wb(1, `MCEP_FL_DATA, 32'h5A5A_0F0F);
		wb(1, `MCEP_FL_ADDR, 32'h0002_0804);
		wb(1, `MCEP_FL_CMD, {30'h0, `MCEP_CMD_PROG});
		chk(fl_prog_o, 1'b1);
		chk({fl_paddr_o, 16'h0}, 32'h8201_0000);
		chk(fl_pdata_o, 32'h5A5A_0F0F);
		wirq;
		stat(4'h4);
		wb(1, `MCEP_FL_ADDR, 32'h0001_FC00);
		wb(1, `MCEP_FL_CMD, {30'h0, `MCEP_CMD_ERASE});
		chk(fl_erase_o, 1'b1);
		chk(fl_paddr_o[15:8], 8'h7F);
		wb(0, `MCEP_FL_CMD, 32'h0);
		chk(rd, 32'h2);
		ahb(0, 32'h2000_0010, 3'h2, 32'h0);
		chk(rd, 32'hBEEF_AA44);
		chk(fl_erase_o, 1'b1);
		wirq;
		stat(4'h4);
		i = 0;
		while (irq_o !== 1'b0 && i < 10) begin
			@(posedge clk_i);
			i++;
		end
		chk(irq_o, 1'b0);
	endtask
	// protection levels, region blocking and debug lockout
	task automatic t_prot;
		wb(1, `MCEP_RD_BLK_LO, 32'h1);
		ahb(0, 32'h0, 3'h2, 32'h0);
		chk(er, 1'b0);
		wb(1, `MCEP_PROT_LVL, 32'h1);
		ahb(0, 32'h0, 3'h2, 32'h0);
		chk(er, 1'b1);
		ahb(0, 32'h0000_0800, 3'h2, 32'h0);
		chk(rd, 32'hFDFF_0200);
		chk(debug_en_o, 1'b1);
		wb(1, `MCEP_WR_BLK_HI, 32'h8000_0000);
		wb(1, `MCEP_FL_CMD, {30'h0, `MCEP_CMD_PROG});
		wirq;
		chk(fl_prog_o, 1'b0);
		stat(4'h8);
		wb(1, `MCEP_PROT_LVL, 32'h2);
		chk(debug_en_o, 1'b0);
		wb(1, `MCEP_PROT_LVL, 32'h3);
		wb(1, `MCEP_PROT_LVL, 32'h0);
		wb(0, `MCEP_PROT_LVL, 32'h0);
		chk(rd[1:0], 2'h3);
		chk(debug_en_o, 1'b0);
		ahb(0, 32'h0, 3'h2, 32'h0);
		chk(er, 1'b1);
	endtask
	// code words: one flipped bit corrected, two flipped bits flagged
	task automatic t_ecc;
		logic [38:0] cw;
		logic [33:0] dr;
		cw = uut.ecc_enc(32'h1122_3344);
		dr = uut.ecc_dec(cw ^ 39'h00_0000_0020);
		chk(dr[31:0], 32'h1122_3344);
		chk(dr[33:32], 2'h1);
		dr = uut.ecc_dec(cw ^ 39'h00_0010_0020);
		chk(dr[33:32], 2'h2);
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset;
		t_sram;
		t_flash;
		t_cmd;
		t_prot;
		t_ecc;
		summarize;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		summarize;
	end
endmodule
